// ===== branch_decode_defines.svh
// Constants for the branch and move decoder
`ifndef BRANCH_DECODE_DEFINES_SVH
`define BRANCH_DECODE_DEFINES_SVH
`define OP_INC_MEM_HI 8'h0e
`define OP_MOV_CNT_HI 8'h3b
`define OP_MOV_CNT_LO 8'h3a
`define OP_MOV_REG_PFX 4'h2
`define PFX_OPBIT 3'h4
`define PFX_ALWAYS 4'he
`define PFX_CARRY 5'h18
`define PFX_NO_CARRY 5'h19
`define PFX_OPER_NZ 5'h17
`define PFX_OPER_Z 5'h16
`define PFX_REG0_NZ 5'h14
`define PFX_REG1_NZ 5'h15
`define PFX_REG4_NZ 5'h1b
`define PFX_TIMEOUT 5'h1a
`define PC_RESET 12'h000
`define NIB_RESET 4'h0
`endif

// ===== branch_decode_pkg.sv
// Types for the branch and move decoder
package branch_decode_pkg;
  typedef enum logic [1:0] {
    ST_FETCH1 = 2'b00,
    ST_FETCH2 = 2'b01,
    ST_MEMWR = 2'b10
  } exec_state_t;
endpackage

// ===== nibble_cpu_branch_decode.sv
// Decode and execute of memory increment, jumps and register moves
`timescale 1ns/10ps
`default_nettype none
`include "branch_decode_defines.svh"

// Contract
// - 0x0E increments memory at high pair
// - Bit-test branch on operand register bit n
// - Conditional branch loads pc bits 0-10
// - Branch when carry is one
// - Branch when carry is zero
// - Unconditional jump loads full 12 bits
// - Branch when operand register nonzero
// - Branch when operand register zero
// - Branch on general reg 0,1,4 nonzero
// - Branch when timeout flag is one
// - Copy general register n to operand
// - Load counter upper nibble to operand
// - Load counter lower nibble to operand
module nibble_cpu_branch_decode
  import branch_decode_pkg::*;
#(
  parameter int DMEM_DEPTH = 160
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Program memory fetch
  input wire logic [7:0] opcode_i,
  output logic [11:0] pc_o,
  output logic rom_bank_select_o,
  // Status from the rest of the core
  input wire logic carry_i,
  input wire logic timeout_flag_i,
  input wire logic [7:0] timer_count_i,
  input wire logic [3:0] operand_load_i,
  input wire logic operand_load_en_i,
  // Visible state
  output logic [3:0] main_operand_o,
  output logic [19:0] general_regs_o,
  output logic [3:0] mem_rd_data_o,
  input wire logic [7:0] mem_rd_addr_i
);

  // An 8-bit register pair cannot reach more than 256 nibbles
  if (DMEM_DEPTH < 1 || DMEM_DEPTH > 256) begin : g_depth_check
    $error("DMEM_DEPTH must be 1 to 256");
  end

  exec_state_t state_reg;
  logic [11:0] pc_reg;
  logic bank_reg;
  logic [3:0] main_operand_reg;
  logic [3:0] general_regs [0:4];
  logic [3:0] dmem [0:DMEM_DEPTH-1];
  logic [7:0] first_byte_reg;
  logic [3:0] mem_rd_data_reg;
  logic branch_cond;
  logic [7:0] pair_addr;
  logic [4:0] pfx;
  logic [11:0] pc_plus1;
  logic [11:0] pc_next;

  function automatic logic valid_reg_index(input logic [2:0] idx);
    valid_reg_index = (idx <= 3'd4);
  endfunction

  assign pfx = first_byte_reg[7:3];
  assign pc_plus1 = pc_reg + 12'h001;
  assign pair_addr = {general_regs[3], general_regs[2]};

  // Branch condition of the two-byte form held in first_byte_reg
  always_comb begin
    branch_cond = 1'b0;
    if (first_byte_reg[7:5] == `PFX_OPBIT) begin
      branch_cond = main_operand_reg[first_byte_reg[4:3]];
    end else begin
      case (pfx)
        `PFX_CARRY: branch_cond = carry_i;
        `PFX_NO_CARRY: branch_cond = ~carry_i;
        `PFX_OPER_NZ: branch_cond = (main_operand_reg != 4'h0);
        `PFX_OPER_Z: branch_cond = (main_operand_reg == 4'h0);
        `PFX_REG0_NZ: branch_cond = (general_regs[0] != 4'h0);
        `PFX_REG1_NZ: branch_cond = (general_regs[1] != 4'h0);
        `PFX_REG4_NZ: branch_cond = (general_regs[4] != 4'h0);
        `PFX_TIMEOUT: branch_cond = timeout_flag_i;
        default: branch_cond = 1'b0;
      endcase
    end
  end

  function automatic logic is_two_byte(input logic [7:0] op);
    is_two_byte = op[7] && (op[7:4] != 4'hf);
  endfunction

  // Program counter next value in second fetch cycle
  always_comb begin
    pc_next = pc_plus1;
    if (first_byte_reg[7:4] == `PFX_ALWAYS) begin
      pc_next = {first_byte_reg[3:0], opcode_i};
    end else if (branch_cond) begin
      pc_next = {pc_reg[11], first_byte_reg[2:0], opcode_i};
    end else begin
      pc_next = pc_plus1;
    end
  end

  // Sequencer and program counter
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_FETCH1;
      pc_reg <= `PC_RESET;
      first_byte_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_FETCH1: begin
          pc_reg <= pc_plus1;
          first_byte_reg <= opcode_i;
          if (is_two_byte(opcode_i)) begin
            state_reg <= ST_FETCH2;
          end else if (opcode_i == `OP_INC_MEM_HI) begin
            state_reg <= ST_MEMWR;
          end
        end
        ST_FETCH2: begin
          pc_reg <= pc_next;
          state_reg <= ST_FETCH1;
        end
        ST_MEMWR: begin
          state_reg <= ST_FETCH1;
        end
        default: state_reg <= ST_FETCH1;
      endcase
    end
  end

  // Bank select is left alone by every jump here
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_reg <= 1'b0;
    end else begin
      bank_reg <= bank_reg;
    end
  end

  // Operand register moves
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_operand_reg <= `NIB_RESET;
    end else if (state_reg == ST_FETCH1) begin
      if (opcode_i[7:4] == `OP_MOV_REG_PFX && opcode_i[0] && valid_reg_index(opcode_i[3:1])) begin
        main_operand_reg <= general_regs[opcode_i[3:1]];
      end else if (opcode_i == `OP_MOV_CNT_HI) begin
        main_operand_reg <= timer_count_i[7:4];
      end else if (opcode_i == `OP_MOV_CNT_LO) begin
        main_operand_reg <= timer_count_i[3:0];
      end else if (operand_load_en_i) begin
        main_operand_reg <= operand_load_i;
      end
    end
  end

  // General registers load from the operand register on opcode 0010nnn0
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_regs
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          general_regs[gi] <= `NIB_RESET;
        end else if (state_reg == ST_FETCH1 && opcode_i[7:4] == `OP_MOV_REG_PFX && !opcode_i[0]
                     && opcode_i[3:1] == 3'(gi)) begin
          general_regs[gi] <= main_operand_reg;
        end
      end
      assign general_regs_o[gi*4 +: 4] = general_regs[gi];
    end
  endgenerate

  // Data memory increment, carry untouched; cleared at reset so increments start known
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DMEM_DEPTH; i++) begin
        dmem[i] <= `NIB_RESET;
      end
    end else if (state_reg == ST_MEMWR && int'(pair_addr) < DMEM_DEPTH) begin
      dmem[pair_addr] <= dmem[pair_addr] + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_data_reg <= `NIB_RESET;
    end else if (int'(mem_rd_addr_i) < DMEM_DEPTH) begin
      mem_rd_data_reg <= dmem[mem_rd_addr_i];
    end else begin
      mem_rd_data_reg <= 4'h0;
    end
  end

  assign pc_o = pc_reg;
  assign rom_bank_select_o = bank_reg;
  assign main_operand_o = main_operand_reg;
  assign mem_rd_data_o = mem_rd_data_reg;

  a_cond_keeps_b11: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && branch_cond && first_byte_reg[7:4] != `PFX_ALWAYS) |=> pc_reg[11] == $past(pc_reg[11]))
    else $error("pc bit 11 changed on conditional branch");
  a_untaken_plus_two: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && is_two_byte(opcode_i)) ##1 (first_byte_reg[7:4] != `PFX_ALWAYS && !branch_cond)
    |=> pc_reg == $past(pc_reg, 2) + 12'h002)
    else $error("untaken branch did not advance by two");
  a_taken_low_bits: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && branch_cond && first_byte_reg[7:4] != `PFX_ALWAYS)
    |=> pc_reg[10:0] == {$past(first_byte_reg[2:0]), $past(opcode_i)})
    else $error("taken branch target wrong");
  a_jump_full: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && first_byte_reg[7:4] == `PFX_ALWAYS)
    |=> pc_reg == {$past(first_byte_reg[3:0]), $past(opcode_i)})
    else $error("jump target wrong");
  a_carry_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_CARRY) |-> branch_cond == carry_i)
    else $error("carry branch condition wrong");
  a_nocarry_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_NO_CARRY) |-> branch_cond != carry_i)
    else $error("no-carry branch condition wrong");
  a_timeout_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_TIMEOUT) |-> branch_cond == timeout_flag_i)
    else $error("timeout branch condition wrong");
  a_cnt_hi_move: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && opcode_i == `OP_MOV_CNT_HI) |=> main_operand_reg == $past(timer_count_i[7:4]))
    else $error("counter upper nibble not loaded");
  a_cnt_lo_move: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && opcode_i == `OP_MOV_CNT_LO) |=> main_operand_reg == $past(timer_count_i[3:0]))
    else $error("counter lower nibble not loaded");
  a_zero_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_OPER_Z) |-> branch_cond == (main_operand_reg == 4'h0))
    else $error("zero branch condition wrong");
  a_reg_nz_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_REG4_NZ) |-> branch_cond == (general_regs[4] != 4'h0))
    else $error("register nonzero branch wrong");
  a_inc_two_cycles: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && opcode_i == `OP_INC_MEM_HI) |=> state_reg == ST_MEMWR ##1 state_reg == ST_FETCH1)
    else $error("increment sequence wrong");

  // Program counter stepping, return to first fetch and bank select hold
  a_fetch_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && !is_two_byte(opcode_i)) |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("one-byte fetch did not advance by one");
  a_fetch2_return: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2) |=> state_reg == ST_FETCH1)
    else $error("second byte did not end the instruction");
  a_memwr_holds_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_MEMWR) |=> $stable(pc_reg))
    else $error("pc moved during memory write cycle");
  a_bank_steady: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2) |=> $stable(rom_bank_select_o))
    else $error("bank select changed on a branch");

  // Branch conditions and their outcomes on the program counter
  a_opbit_taken: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && first_byte_reg[7:5] == `PFX_OPBIT && main_operand_reg[first_byte_reg[4:3]])
    |=> pc_reg[10:0] == {$past(first_byte_reg[2:0]), $past(opcode_i)})
    else $error("operand bit branch not taken");
  a_carry_taken: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_CARRY && carry_i)
    |=> pc_reg[10:0] == {$past(first_byte_reg[2:0]), $past(opcode_i)})
    else $error("carry branch not taken");
  a_nocarry_taken: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_NO_CARRY && !carry_i)
    |=> pc_reg[10:0] == {$past(first_byte_reg[2:0]), $past(opcode_i)})
    else $error("no-carry branch not taken");
  a_oper_nz_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_OPER_NZ) |-> branch_cond == (main_operand_reg != 4'h0))
    else $error("nonzero branch condition wrong");
  a_oper_nz_skip: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_OPER_NZ && main_operand_reg == 4'h0) |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("nonzero branch did not skip");
  a_zero_skip: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_OPER_Z && main_operand_reg != 4'h0) |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("zero branch did not skip");
  a_reg0_nz_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_REG0_NZ) |-> branch_cond == (general_regs[0] != 4'h0))
    else $error("register 0 branch condition wrong");
  a_reg1_nz_branch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_REG1_NZ) |-> branch_cond == (general_regs[1] != 4'h0))
    else $error("register 1 branch condition wrong");
  a_reg4_skip: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_REG4_NZ && general_regs[4] == 4'h0) |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("register 4 branch did not skip");
  a_timeout_fall: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH2 && pfx == `PFX_TIMEOUT && !timeout_flag_i) |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("timeout branch did not fall through");

  // Register moves and memory increment
  a_reg_to_operand: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && opcode_i[7:4] == `OP_MOV_REG_PFX && opcode_i[0] && opcode_i[3:1] <= 3'd4)
    |=> main_operand_reg == $past(general_regs[opcode_i[3:1]]))
    else $error("register not copied to operand");
  a_bad_index_ignored: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_FETCH1 && opcode_i[7:4] == `OP_MOV_REG_PFX && opcode_i[0] && opcode_i[3:1] > 3'd4
     && !operand_load_en_i) |=> $stable(main_operand_reg))
    else $error("move from missing register changed operand");
  a_mem_incr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_MEMWR && int'(pair_addr) < DMEM_DEPTH)
    |=> dmem[$past(pair_addr)] == $past(dmem[pair_addr]) + 4'h1)
    else $error("memory nibble not incremented");

  c_jump: cover property (@(posedge mclk_i) state_reg == ST_FETCH2 && first_byte_reg[7:4] == `PFX_ALWAYS);
  c_taken: cover property (@(posedge mclk_i) state_reg == ST_FETCH2 && branch_cond);
  c_untaken: cover property (@(posedge mclk_i) state_reg == ST_FETCH2 && !branch_cond && pfx[4]);
  c_inc: cover property (@(posedge mclk_i) state_reg == ST_MEMWR);
  c_reg_move: cover property (@(posedge mclk_i) state_reg == ST_FETCH1 && opcode_i[7:4] == `OP_MOV_REG_PFX && opcode_i[0]);

endmodule
`default_nettype wire

// ===== nibble_cpu_branch_decode_tb_top.sv
// Self-checking bench for the branch and move decoder
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_branch_decode_tb_top;
  import branch_decode_pkg::*;
  localparam logic [7:0] NOP = 8'h3e;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] opcode_i = 8'h3e;
  logic carry_i = 1'b0;
  logic timeout_flag_i = 1'b0;
  logic [7:0] timer_count_i = 8'h00;
  logic [3:0] operand_load_i = 4'h0;
  logic operand_load_en_i = 1'b0;
  logic [7:0] mem_rd_addr_i = 8'h00;
  logic [11:0] pc_o;
  logic rom_bank_select_o;
  logic [3:0] main_operand_o;
  logic [19:0] general_regs_o;
  logic [3:0] mem_rd_data_o;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  nibble_cpu_branch_decode dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .opcode_i(opcode_i), .pc_o(pc_o),
    .rom_bank_select_o(rom_bank_select_o), .carry_i(carry_i), .timeout_flag_i(timeout_flag_i),
    .timer_count_i(timer_count_i), .operand_load_i(operand_load_i), .operand_load_en_i(operand_load_en_i),
    .main_operand_o(main_operand_o), .general_regs_o(general_regs_o), .mem_rd_data_o(mem_rd_data_o),
    .mem_rd_addr_i(mem_rd_addr_i));
  always #4 mclk_i = ~mclk_i;
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the length of the full sequence
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A byte driven here is consumed at the following edge
  task automatic put(input logic [7:0] b);
    @(posedge mclk_i);
    opcode_i <= b;
  endtask
  task automatic settle();
    put(NOP);
    @(negedge mclk_i);
  endtask
  task automatic set_acc(input logic [3:0] v);
    put(NOP);
    operand_load_i <= v;
    operand_load_en_i <= 1'b1;
    @(posedge mclk_i);
    operand_load_en_i <= 1'b0;
  endtask
  task automatic set_reg(input logic [2:0] n, input logic [3:0] v);
    set_acc(v);
    put({4'h2, n, 1'b0});
  endtask
  // Start at 0x900 so that pc bit 11 is set, then one conditional branch
  task automatic br(input logic [7:0] b1, input logic [7:0] b2, input logic take);
    put(8'he9);
    put(8'h00);
    put(b1);
    put(b2);
    settle();
    chk(20'(pc_o), take ? {8'h00, 1'b1, b1[2:0], b2} : 20'h00902);
    chk(20'(rom_bank_select_o), 20'h0);
  endtask
  task automatic t_jmp();
    put(8'hea);
    put(8'hbc);
    settle();
    chk(20'(pc_o), 20'h00abc);
  endtask
  task automatic t_opbit();
    for (int n = 0; n < 4; n++) begin
      set_acc(4'h1 << n);
      br(8'h83 | 8'(n << 3), 8'h45, 1'b1);
      set_acc(~(4'h1 << n));
      br(8'h83 | 8'(n << 3), 8'h45, 1'b0);
    end
  endtask
  task automatic t_carry();
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk_i);
      carry_i <= c[0];
      br(8'hc5, 8'h6a, c[0]);
      br(8'hcd, 8'h6a, !c[0]);
    end
  endtask
  task automatic t_acc();
    set_acc(4'h0);
    br(8'hb2, 8'h11, 1'b1);
    br(8'hba, 8'h11, 1'b0);
    set_acc(4'h8);
    br(8'hb2, 8'h11, 1'b0);
    br(8'hba, 8'h11, 1'b1);
  endtask
  task automatic t_regs();
    logic [7:0] pfx[3] = '{8'ha0, 8'ha8, 8'hd8};
    logic [2:0] idx[3] = '{3'd0, 3'd1, 3'd4};
    for (int n = 0; n < 5; n++) set_reg(3'(n), 4'h0);
    set_reg(3'd2, 4'hf);
    set_reg(3'd3, 4'hf);
    for (int k = 0; k < 3; k++) begin
      br(pfx[k] | 8'h07, 8'hfe, 1'b0);
      set_reg(idx[k], 4'h2);
      br(pfx[k] | 8'h07, 8'hfe, 1'b1);
      set_reg(idx[k], 4'h0);
    end
  endtask
  task automatic t_timeout();
    for (int t = 0; t < 2; t++) begin
      @(posedge mclk_i);
      timeout_flag_i <= t[0];
      br(8'hd6, 8'h9c, t[0]);
    end
  endtask
  task automatic t_moves();
    for (int n = 0; n < 5; n++) set_reg(3'(n), 4'(n + 3));
    settle();
    chk(general_regs_o, 20'h76543);
    for (int n = 0; n < 5; n++) begin
      set_acc(4'h0);
      put({4'h2, 3'(n), 1'b1});
      settle();
      chk(20'(main_operand_o), 20'(n + 3));
    end
    // Register index 7 does not exist, so the operand keeps 7
    put(8'h2f);
    settle();
    chk(20'(main_operand_o), 20'h7);
    @(posedge mclk_i);
    timer_count_i <= 8'h5c;
    put(8'h3b);
    settle();
    chk(20'(main_operand_o), 20'h5);
    put(8'h3a);
    settle();
    chk(20'(main_operand_o), 20'hc);
  endtask
  // Pair r3:r2 = 1:5 addresses nibble 0x15; a swapped pair would hit 0x51
  task automatic t_inc();
    set_reg(3'd2, 4'h5);
    set_reg(3'd3, 4'h1);
    for (int k = 1; k < 3; k++) begin
      put(8'h0e);
      mem_rd_addr_i <= 8'h15;
      put(NOP);
      settle();
      settle();
      chk(20'(mem_rd_data_o), 20'(k));
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk(20'(pc_o), 20'h0);
    chk(general_regs_o, 20'h0);
    chk(20'(main_operand_o), 20'h0);
    chk(20'(mem_rd_data_o), 20'h0);
    t_jmp();
    t_opbit();
    t_carry();
    t_acc();
    t_regs();
    t_timeout();
    t_moves();
    t_inc();
    complete_run();
  end
endmodule
`default_nettype wire
